/* rtl/pwmsc_pkg.sv */
// Package for the 12-bit sub-cycle pulse width modulator.
// Assumes a single system clock and a plain register port.
package pwmsc_pkg;
  localparam int PWMSC_CHANNELS = 4;
  localparam int PWMSC_ADDR_W = 4;
  localparam int PWMSC_DATA_W = 8;
  localparam int PWMSC_DUTY_W = 12;
  localparam int PWMSC_CNT_W = 12;
  localparam int PWMSC_SUB_W = 8;
  localparam int PWMSC_COARSE_LSB = 4;
  localparam int PWMSC_FINE_W = 4;
  localparam logic [PWMSC_ADDR_W-1:0] PWMSC_LOW_BASE = 4'h0;
  localparam logic [PWMSC_ADDR_W-1:0] PWMSC_HIGH_BASE = 4'h4;
  localparam logic [PWMSC_ADDR_W-1:0] PWMSC_PORT_DATA = 4'h8;
  localparam logic [PWMSC_ADDR_W-1:0] PWMSC_PORT_DIR = 4'h9;
  localparam logic [PWMSC_ADDR_W-1:0] PWMSC_PIN_READ = 4'hA;
  localparam int PWMSC_EN_BIT = 0;
  localparam int PWMSC_FINE_LSB = 4;
  localparam logic [7:0] PWMSC_DUTY_RST = 8'h00;
  localparam logic [7:0] PWMSC_DIR_RST = 8'hFF;
  localparam logic [7:0] PWMSC_DATA_RST = 8'h00;
  localparam logic [7:0] PWMSC_LOW_MASK = 8'hF1;
endpackage : pwmsc_pkg

/* rtl/pwmsc_chan_if.sv */
// Interface carrying one channel's duty and timing to its waveform unit.
// Assumes all signals belong to sys_clk.
`timescale 1ns/100ps
interface pwmsc_chan_if;
  import pwmsc_pkg::*;
  logic [PWMSC_DUTY_W-1:0] duty;
  logic [PWMSC_CNT_W-1:0] count;
  logic wave;
  modport ctl (output duty, output count, input wave);
  modport unit (input duty, input count, output wave);
endinterface : pwmsc_chan_if

/* rtl/pwmsc_chan.sv */
// One channel's waveform: coarse duty stretched by fine fraction.
// Assumes duty is already latched at cycle start.
`timescale 1ns/100ps
module pwmsc_chan (
  input wire logic sys_clk,
  input wire logic rst,
  pwmsc_chan_if.unit ch
);
  import pwmsc_pkg::*;
  logic [PWMSC_SUB_W-1:0] coarse_duty;
  logic [PWMSC_FINE_W-1:0] fine_fraction;
  logic [PWMSC_FINE_W-1:0] sub_idx;
  logic [PWMSC_SUB_W-1:0] pos;
  logic extra;
  logic next_wave;
  logic wave;

  assign ch.wave = wave;

  always_comb begin
    coarse_duty = ch.duty[PWMSC_DUTY_W-1:PWMSC_COARSE_LSB];
    fine_fraction = ch.duty[PWMSC_FINE_W-1:0];
    sub_idx = ch.count[PWMSC_CNT_W-1:PWMSC_SUB_W];
    pos = ch.count[PWMSC_SUB_W-1:0];
    extra = (sub_idx < fine_fraction);
    // High for coarse clocks, plus one where extra
    next_wave = (pos < coarse_duty) || (extra && pos == coarse_duty);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end
endmodule : pwmsc_chan

/* rtl/pwmsc_top.sv */
// Top of the multi-channel 12-bit sub-cycle pulse width modulator.
// Assumes one system clock, synchronous reset and a plain register port.
`timescale 1ns/100ps
module pwmsc_top #(
  parameter int CHANNELS = pwmsc_pkg::PWMSC_CHANNELS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [pwmsc_pkg::PWMSC_ADDR_W-1:0] reg_addr,
  input wire logic [pwmsc_pkg::PWMSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pwmsc_pkg::PWMSC_DATA_W-1:0] reg_rdata,
  input wire logic [CHANNELS-1:0] shared_output_pins_in,
  output logic [CHANNELS-1:0] shared_output_pins_out,
  output logic [CHANNELS-1:0] shared_output_pins_oe,
  output logic [CHANNELS-1:0] shared_output_pins_pullup,
  output logic [CHANNELS-1:0] modulated_outputs
);
  import pwmsc_pkg::*;

  logic [7:0] duty_low_regs [CHANNELS];
  logic [7:0] duty_high_regs [CHANNELS];
  logic [7:0] next_duty_low [CHANNELS];
  logic [7:0] next_duty_high [CHANNELS];
  logic [CHANNELS-1:0] port_d_output_latch;
  logic [CHANNELS-1:0] next_port_data;
  logic [CHANNELS-1:0] port_dir;
  logic [CHANNELS-1:0] next_port_dir;
  logic [CHANNELS-1:0] pullup_sel;
  logic [CHANNELS-1:0] next_pullup_sel;
  logic [7:0] next_rdata;

  logic [PWMSC_CNT_W-1:0] cycle_cnt;
  logic [PWMSC_CNT_W-1:0] next_cycle_cnt;
  logic [PWMSC_DUTY_W-1:0] duty_act [CHANNELS];
  logic [PWMSC_DUTY_W-1:0] next_duty_act [CHANNELS];
  logic [CHANNELS-1:0] wave;
  logic [CHANNELS-1:0] next_out;
  logic [CHANNELS-1:0] next_oe;
  logic [CHANNELS-1:0] next_mod;

  logic [CHANNELS-1:0] pin_s1;
  logic [CHANNELS-1:0] pin_s2;
  logic [CHANNELS-1:0] pin_s3;
  logic [CHANNELS-1:0] pin_val;
  logic [CHANNELS-1:0] next_pin_val;

  logic [7:0] pin_word;
  logic [7:0] data_word;
  logic [7:0] dir_word;

  // Free-running cycle counter on the system clock
  always_comb begin
    next_cycle_cnt = cycle_cnt + 12'h001;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cycle_cnt <= 12'h000;
    end else begin
      cycle_cnt <= next_cycle_cnt;
    end
  end

  // Register writes
  always_comb begin
    next_port_data = port_d_output_latch;
    next_port_dir = port_dir;
    next_pullup_sel = pullup_sel;
    for (int c = 0; c < CHANNELS; c++) begin
      next_duty_low[c] = duty_low_regs[c];
      next_duty_high[c] = duty_high_regs[c];
    end
    if (reg_wr) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (reg_addr == PWMSC_LOW_BASE + PWMSC_ADDR_W'(c)) begin
          next_duty_low[c] = reg_wdata & PWMSC_LOW_MASK;
        end else if (reg_addr == PWMSC_HIGH_BASE + PWMSC_ADDR_W'(c)) begin
          next_duty_high[c] = reg_wdata;
        end
      end
      if (reg_addr == PWMSC_PORT_DATA) begin
        next_port_data = reg_wdata[CHANNELS-1:0];
      end else if (reg_addr == PWMSC_PORT_DIR) begin
        next_port_dir = reg_wdata[CHANNELS-1:0];
        next_pullup_sel = reg_wdata[CHANNELS+3:4];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_d_output_latch <= PWMSC_DATA_RST[CHANNELS-1:0];
      port_dir <= PWMSC_DIR_RST[CHANNELS-1:0];
      pullup_sel <= PWMSC_DIR_RST[CHANNELS+3:4];
      for (int c = 0; c < CHANNELS; c++) begin
        duty_low_regs[c] <= PWMSC_DUTY_RST;
        duty_high_regs[c] <= PWMSC_DUTY_RST;
      end
    end else begin
      port_d_output_latch <= next_port_data;
      port_dir <= next_port_dir;
      pullup_sel <= next_pullup_sel;
      for (int c = 0; c < CHANNELS; c++) begin
        duty_low_regs[c] <= next_duty_low[c];
        duty_high_regs[c] <= next_duty_high[c];
      end
    end
  end

  // Duty latched only at full-cycle wrap
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_duty_act[c] = duty_act[c];
      if (next_cycle_cnt == 12'h000) begin
        next_duty_act[c] = {duty_high_regs[c],
                            duty_low_regs[c][7:PWMSC_FINE_LSB]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        duty_act[c] <= 12'h000;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        duty_act[c] <= next_duty_act[c];
      end
    end
  end

  // One waveform unit per channel
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    pwmsc_chan_if cif ();
    assign cif.duty = duty_act[g];
    assign cif.count = cycle_cnt;
    assign wave[g] = cif.wave;
    pwmsc_chan u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .ch(cif.unit)
    );
  end

  // Pin gating
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_mod[c] = duty_low_regs[c][PWMSC_EN_BIT] & wave[c];
      if (duty_low_regs[c][PWMSC_EN_BIT]) begin
        next_out[c] = port_d_output_latch[c] & wave[c];
      end else begin
        next_out[c] = port_d_output_latch[c];
      end
      next_oe[c] = ~port_dir[c];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shared_output_pins_out <= '0;
      shared_output_pins_oe <= '0;
      shared_output_pins_pullup <= '0;
      modulated_outputs <= '0;
    end else begin
      shared_output_pins_out <= next_out;
      shared_output_pins_oe <= next_oe;
      shared_output_pins_pullup <= pullup_sel & port_dir;
      modulated_outputs <= next_mod;
    end
  end

  // Pin input synchroniser, change accepted when stages 2 and 3 agree
  always_comb begin
    next_pin_val = pin_val;
    for (int c = 0; c < CHANNELS; c++) begin
      if (pin_s2[c] == pin_s3[c]) begin
        next_pin_val[c] = pin_s3[c];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_val <= '0;
    end else begin
      pin_s1 <= shared_output_pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_val <= next_pin_val;
    end
  end

  // Register reads
  always_comb begin
    pin_word = '0;
    data_word = '0;
    dir_word = '0;
    pin_word[CHANNELS-1:0] = pin_val;
    data_word[CHANNELS-1:0] = port_d_output_latch;
    dir_word[CHANNELS-1:0] = port_dir;
    dir_word[CHANNELS+3:4] = pullup_sel;
    next_rdata = 8'h00;
    if (reg_rd) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (reg_addr == PWMSC_LOW_BASE + PWMSC_ADDR_W'(c)) begin
          next_rdata = duty_low_regs[c];
        end else if (reg_addr == PWMSC_HIGH_BASE + PWMSC_ADDR_W'(c)) begin
          next_rdata = duty_high_regs[c];
        end
      end
      if (reg_addr == PWMSC_PORT_DATA) begin
        next_rdata = data_word;
      end else if (reg_addr == PWMSC_PORT_DIR) begin
        next_rdata = dir_word;
      end else if (reg_addr == PWMSC_PIN_READ) begin
        next_rdata = pin_word;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : pwmsc_top

/* verification/pwmsc_chk.sv */
// Port checker for the sub-cycle modulator.
// Assumes it is bound into pwmsc_top.
`timescale 1ns/100ps
module pwmsc_chk #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [CHANNELS-1:0] shared_output_pins_out,
  input wire logic [CHANNELS-1:0] shared_output_pins_oe,
  input wire logic [CHANNELS-1:0] shared_output_pins_pullup,
  input wire logic [CHANNELS-1:0] modulated_outputs
);
  logic [7:0] dir_w, dat_w, gap;
  logic [2:0] qd, qp;
  logic seen;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Last port writes, cycles since them, and gap between wave rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_w <= 8'hFF;
      dat_w <= 8'h00;
      qd <= 3'h7;
      qp <= 3'h7;
      seen <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h9) dir_w <= reg_wdata;
      if (reg_wr && reg_addr == 4'h8) dat_w <= reg_wdata;
      qd <= (reg_wr && reg_addr == 4'h9) ? 3'h0 : qd + 3'(qd != 3'h7);
      qp <= (reg_wr && reg_addr == 4'h8) ? 3'h0 : qp + 3'(qp != 3'h7);
      if ($rose(modulated_outputs[0])) seen <= 1'b1;
    end
    gap <= $rose(modulated_outputs[0]) ? 8'h00 : gap + 8'h01;
  end
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_a: assert property (reg_rd && reg_addr > 4'hA |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  low_mask_a: assert property (reg_rd && reg_addr < 4'h4 |=>
    (reg_rdata & 8'h0E) == 8'h00) else $error("low reg spare bits");
  write_read_a: assert property (reg_wr && reg_addr == 4'h4 ##1
    reg_rd && reg_addr == 4'h4 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("high reg readback");
  sub_phase_a: assert property ($rose(modulated_outputs[0]) && seen |->
    gap == 8'hFF) else $error("rise off sub-cycle start");
  oe_dir_a: assert property (qd == 3'h3 |->
    shared_output_pins_oe == ~dir_w[3:0]) else $error("enable vs direction");
  pullup_a: assert property (qd == 3'h3 |->
    shared_output_pins_pullup == (dir_w[7:4] & dir_w[3:0]))
    else $error("pull-high select");
  data_low_a: assert property (qp == 3'h3 && dat_w[3:0] == 4'h0 |->
    shared_output_pins_out == 4'h0) else $error("pin not forced low");
endmodule : pwmsc_chk
bind pwmsc_top pwmsc_chk #(.CHANNELS(CHANNELS)) u_pwmsc_chk (.sys_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .shared_output_pins_out,
  .shared_output_pins_oe, .shared_output_pins_pullup, .modulated_outputs);

/* verification/pwmsc_load.sv */
// Load on the shared pins: resolves each pin's level.
// Assumes drive, enable and pull-high per pin from the block.
`timescale 1ns/100ps
module pwmsc_load (
  input wire logic [3:0] drive,
  input wire logic [3:0] oe,
  input wire logic [3:0] pull_high,
  output logic [3:0] level
);
  // Undriven pin without pull-high shows the inverse of the drive
  assign level = oe & drive | ~oe & (pull_high | ~drive);
endmodule : pwmsc_load

/* verification/pwmsc_top_test.sv */
// Bench for pwmsc_top with a cycle model and a pin load.
// Assumes a 50 MHz sys_clk and reset held five cycles.
`timescale 1ns/100ps
module pwmsc_top_test;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pend = 0;
  logic [3:0] reg_addr = 0, pins, p_out, p_oe, p_pu, w1, ex, dat;
  logic [3:0] en, mx, oex, pux, m_out;
  logic [7:0] reg_wdata = 0, reg_rdata, er, dir, hi [4], lo [4];
  logic [11:0] d, tbl [4] = '{12'h641, 12'h000, 12'hFFF, 12'h10F};
  int bad_count = 0, checks = 0, cnt, lat [4];
  pwmsc_top u_pwmsc_top (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .shared_output_pins_in(pins),
    .shared_output_pins_out(p_out), .shared_output_pins_oe(p_oe),
    .shared_output_pins_pullup(p_pu), .modulated_outputs(m_out));
  pwmsc_load u_pwmsc_load (.drive(p_out), .oe(p_oe), .pull_high(p_pu),
    .level(pins));
  initial forever #10 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
  endtask : bus
  task automatic idle;
    @(posedge sys_clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask : idle
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Model: counter, wave stage, pin stage and register shadows
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt = 0;
      w1 = 0;
      ex = 0;
      en = 0;
      mx = 0;
      oex = 0;
      pux = 0;
      dat = 0;
      dir = 8'hFF;
      hi = '{default: 0};
      lo = '{default: 0};
      lat = '{default: 0};
    end else begin
      foreach (en[k]) en[k] = lo[k][0];
      ex = dat & (w1 | ~en);
      mx = en & w1;
      oex = ~dir[3:0];
      pux = dir[7:4] & dir[3:0];
      foreach (w1[k]) w1[k] = cnt % 256 < lat[k] / 16 ||
        (cnt % 256 == lat[k] / 16 && cnt / 256 < lat[k] % 16);
      if (cnt == 4095) foreach (lat[k]) lat[k] = hi[k] * 16 + lo[k] / 16;
      cnt = (cnt + 1) % 4096;
    end
    pend = reg_rd;
    er = reg_addr[3] ? (reg_addr == 4'h8 ? {4'h0, dat} :
      reg_addr == 4'h9 ? dir :
      reg_addr == 4'hA ? {4'h0, pins} : 8'h00) :
      reg_addr[2] ? hi[reg_addr[1:0]] : lo[reg_addr[1:0]] & 8'hF1;
    if (reg_wr && reg_addr < 4'h4) lo[reg_addr[1:0]] = reg_wdata;
    if (reg_wr && reg_addr[3:2] == 2'h1) hi[reg_addr[1:0]] = reg_wdata;
    if (reg_wr && reg_addr == 4'h8) dat = reg_wdata[3:0];
    if (reg_wr && reg_addr == 4'h9) dir = reg_wdata;
  end
  always @(negedge sys_clk) begin
    if (!rst) check(p_out, ex);
    if (!rst) check(m_out, mx);
    if (!rst) check(p_oe, oex);
    if (!rst) check(p_pu, pux);
    if (pend) check(reg_rdata, er);
  end
  initial begin
    void'($urandom(30));
    repeat (5) @(posedge sys_clk);
    rst <= 0;
    for (int a = 11; a < 16; a++) bus(0, 4'(a), 0);
    bus(0, 4'h9, 0);
    bus(0, 4'hA, 0);
    bus(1, 4'h8, 0);
    bus(1, 4'h9, 8'hF0);
    for (int p = 0; p < 6; p++) begin
      for (int k = 0; k < 4; k++) begin
        d = p == 1 ? tbl[k] : 12'($urandom % 4096);
        bus(1, 4'(k + 4), d[11:4]);
        bus(0, 4'(k + 4), 0);
        bus(1, 4'(k), {d[3:0], 4'hF});
        bus(0, 4'(k), 0);
      end
      bus(0, 4'hB, 0);
      bus(0, 4'h0, 0);
      idle;
      repeat (4096 + $urandom % 4096) @(posedge sys_clk);
      if (p == 0) bus(1, 4'h8, 8'h0F);
    end
    bus(1, 4'h8, 0);
    bus(1, 4'h9, 8'h31);
    idle;
    repeat (8) @(posedge sys_clk);
    bus(0, 4'hA, 0);
    bus(0, 4'h8, 0);
    idle;
    repeat (4) @(posedge sys_clk);
    give_verdict;
  end
endmodule : pwmsc_top_test
